// ### asr_host_model.sv
// Purpose: Host model: reads frames, programs.
// Assumes: 6 ns base clock; a half period is 84 ticks.
// Notes:   A released data line reads as a toggling value.
`timescale 1ns/100ps
`default_nettype none

module asr_host_model (
   // Base clock and data pin
   input  wire logic link_clk_in,
   input  wire logic sdo_in,
   input  wire logic sdo_oe_in,
   // Host pins
   output var logic  read_clk_out,
   output var logic  chip_select_n_out,
   output var logic  prog_out
);
   // ********************
   // Line level and frame tasks
   // ********************
   localparam int HALF = 84;
   logic last_lvl = 1'b0;
   logic line;

   // Undriven line shows the inverse of its last level
   assign line = sdo_oe_in ? sdo_in : ~last_lvl;
   always @(posedge link_clk_in) begin
      last_lvl <= line;
   end

   initial begin
      read_clk_out = 1'b1;
      chip_select_n_out = 1'b1;
      prog_out = 1'b0;
   end

   // Half period of 504 ns
   task automatic half();
      repeat (HALF) @(posedge link_clk_in);
   endtask

   // One frame of 18 bits
   task automatic read_frame(output logic [17:0] w, output logic act, output logic rel);
      half();
      chip_select_n_out = 1'b0;
      half();
      act = sdo_oe_in & line;
      read_clk_out = 1'b0;
      for (int k = 17; k >= 0; k--) begin
         half();
         read_clk_out = 1'b1;
         half();
         w[k] = line;
         read_clk_out = 1'b0;
      end
      half();
      read_clk_out = 1'b1;
      half();
      rel = ~sdo_oe_in;
      chip_select_n_out = 1'b1;
      half();
   endtask

   // Program entry, then 16 bits at about 248 kHz, changed at the clock fall
   task automatic enter_prog(input logic [15:0] d);
      half();
      prog_out = 1'b1;
      repeat (4) half();
      chip_select_n_out = 1'b0;
      half();
      chip_select_n_out = 1'b1;
      for (int k = 15; k >= 0; k--) begin
         read_clk_out = 1'b0;
         prog_out = d[k];
         repeat (4) half();
         read_clk_out = 1'b1;
         repeat (4) half();
      end
      prog_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### asr_link_shift.sv
// Purpose: Output shift register on the host read clock.
// Assumes: word_in stable through the frame.
// Notes:   Cleared while chip select is high.
`timescale 1ns/100ps
`default_nettype none

module asr_link_shift #(
   parameter int WORD_BITS = 18
) (
   // Link clock and frame clear
   input  wire logic                 link_clk_in,
   input  wire logic                 clear_in,
   // Word and serial bit
   input  wire logic [WORD_BITS-1:0] word_in,
   output logic                      bit_out,
   output logic                      done_out
);
   localparam int IDX_W = $clog2(WORD_BITS + 2);

   logic [WORD_BITS-1:0] shreg;
   logic                 loaded;
   logic [IDX_W-1:0]     idx;
   wire  [IDX_W-1:0]     sel = IDX_W'(WORD_BITS - 1) - idx;

   // Load word on first falling edge of the frame
   always_ff @(negedge link_clk_in or posedge clear_in) begin
      if (clear_in) begin
         shreg  <= '0;
         loaded <= 1'h0;
      end else if (!loaded) begin
         shreg  <= word_in;  // [RQ3]
         loaded <= 1'h1;
      end
   end

   // One bit per rising edge, then flag the end of the word
   always_ff @(posedge link_clk_in or posedge clear_in) begin
      if (clear_in) begin
         idx      <= '0;
         bit_out  <= 1'h1;   // [RQ1]
         done_out <= 1'h0;
      end else if (loaded && !done_out) begin
         if (idx == IDX_W'(WORD_BITS)) begin
            done_out <= 1'h1;  // [RQ9]
         end else begin
            bit_out <= shreg[sel];  // [RQ4]
         end
         idx <= idx + IDX_W'(1);
      end
   end
endmodule

`default_nettype wire

// ### asr_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the angle read-out.
// Assumes: The system clock runs at 40 MHz (25 ns period).
// Notes:   Cycle counts derive from the times.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// ********************
// Serial word layout
// ********************
`define ASR_WORD_BITS          18
`define ASR_ANGLE_BITS         12
`define ASR_POS_ANGLE_LSB      6
`define ASR_POS_OFFSET_DONE    5
`define ASR_POS_OVERFLOW       4
`define ASR_POS_LIN_ALARM      3
`define ASR_POS_FIELD_RISING   2
`define ASR_POS_FIELD_FALLING  1
`define ASR_POS_PARITY         0

// ********************
// Timing
// ********************
`define ASR_CLK_PERIOD_NS      25
`define ASR_DO_ACTIVE_MAX_NS   100
`define ASR_DO_ACTIVE_MAX_CYC  (`ASR_DO_ACTIVE_MAX_NS / `ASR_CLK_PERIOD_NS)
`define ASR_SLOW_DELAY_US      384
`define ASR_FAST_DELAY_US      96
`define ASR_SLOW_DELAY_CYC     ((`ASR_SLOW_DELAY_US * 1000) / `ASR_CLK_PERIOD_NS)
`define ASR_FAST_DELAY_CYC     ((`ASR_FAST_DELAY_US * 1000) / `ASR_CLK_PERIOD_NS)
`define ASR_DELAY_CNT_W        16
`define ASR_US_CYC             (1000 / `ASR_CLK_PERIOD_NS)
`define ASR_PWM_PERIOD_US      4097
`define ASR_PWM_CNT_W          13

// ********************
// Reset values
// ********************
`define ASR_SYNC_CS_INIT       1'h1
`define ASR_SYNC_LOW_INIT      1'h0

`endif

// ### asr_pkg.sv
// Purpose: Types shared by the angle read-out modules.
// Assumes: asr_params.svh gives the widths.
// Notes:   None.
`include "asr_params.svh"

package asr_pkg;
   typedef logic [`ASR_WORD_BITS-1:0]  asr_word_t;
   typedef logic [`ASR_ANGLE_BITS-1:0] asr_angle_t;
   typedef enum logic [1:0] {
      ASR_IDLE,
      ASR_DRIVE,
      ASR_DONE,
      ASR_PROG
   } asr_rd_state_t;
endpackage

// ### asr_readout.sv
// Purpose: Angle sensor serial read-out, sample pacing, PWM output and field pins.
// Assumes: Front end and fuses on clk_in.
// Notes:   Function
// Function
// [RQ1] Chip select fall enables serial output, driving high within 100 ns; the code drives it at the fifth clock edge after the fall, 100 to 125 ns.
// [RQ2] Host waits 500 ns after chip select fall before first clock fall.
// [RQ3] First read-clock fall of a frame loads the word into the shifter.
// [RQ4] Each later read-clock rise presents the next word bit.
// [RQ5] Host read clock above zero, at most 1 MHz, half-period 500 ns.
// [RQ6] Word is 18 bits; 12 angle bits MSB first, then six status bits.
// [RQ7] Status order: offset done, overflow, linearity, field rising, field falling, parity.
// [RQ8] Last bit is even parity over the seventeen preceding bits.
// [RQ9] After the last bit the output returns to high impedance within 100 ns; the code releases it 100 to 125 ns after the next read-clock rise.
// [RQ10] Chip select high at least 500 ns starts the next read-out.
// [RQ11] Offset-done bit set once offset compensation has completed.
// [RQ12] On overflow set flag and keep outputting the last valid angle.
// [RQ13] Linearity alarm raised on critical linearity; angle still reported.
// [RQ14] Host trusts angle only with offset done, no overflow, no alarm.
// [RQ15] Default angle code increases for clockwise rotation seen from above.
// [RQ16] Mode low: filter on, 2.61 kHz sampling, 384 us output delay.
// [RQ17] Mode high: filter off, 10.42 kHz sampling, 96 us output delay.
// [RQ18] Mode level fixed before power-up, never changed during operation.
// [RQ19] PWM period 4097 us; high time is code plus one microseconds.
// [RQ20] Host raises program input 2 us before chip select rises.
// [RQ21] Programming bits valid at rising clock, clock at most 250 kHz.
// [RQ22] Fuse burn uses exactly 16 clock pulses of about 2 us.
// [RQ23] Host shifts 16 bits: direction, zero position MSB first, mode bits.
// [RQ24] Field flags: 00 in range, 01 away, 10 approaching, 11 out.
// [RQ25] Programmed settings apply only after the next power-on.
// [RQ26] Loaded word is the latest finished sample, stable until frame end.
`timescale 1ns/100ps
`default_nettype none

module asr_readout
   import asr_pkg::*;
#(
   parameter int SLOW_DELAY_CYC = `ASR_SLOW_DELAY_CYC,
   parameter int FAST_DELAY_CYC = `ASR_FAST_DELAY_CYC,
   parameter int US_CYC         = `ASR_US_CYC
) (
   // System clock and reset
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   // Serial link pins
   input  wire logic       read_clk_in,
   input  wire logic       chip_select_n_in,
   input  wire logic       prog_in,
   output logic            sdo_out,
   output logic            sdo_oe_out,
   // Configuration pins and fuses
   input  wire logic       mode_in,
   input  wire logic       fuse_ccw_in,
   input  wire asr_angle_t fuse_zero_in,
   // Front end
   input  wire asr_angle_t raw_angle_in,
   input  wire logic       offset_comp_done_in,
   input  wire logic       angle_calc_overflow_in,
   input  wire logic       linearity_alarm_in,
   input  wire logic       field_approach_in,
   input  wire logic       field_recede_in,
   input  wire logic       field_out_of_range_in,
   output logic            sample_strobe_out,
   output logic            filter_en_out,
   // Field pins, open drain
   output logic            field_rising_n_out,
   output logic            field_rising_n_oe_out,
   output logic            field_falling_n_out,
   output logic            field_falling_n_oe_out,
   // PWM and status
   output logic            pwm_out,
   output logic            prog_mode_out
);

   // ********************
   // Elaboration checks
   // ********************
   generate
      if (SLOW_DELAY_CYC < 2 || FAST_DELAY_CYC < 2 ||
          SLOW_DELAY_CYC >= (1 << `ASR_DELAY_CNT_W) ||
          FAST_DELAY_CYC >= (1 << `ASR_DELAY_CNT_W)) begin : g_bad_delay
         $error("Sample period counts out of range");
      end
      if (US_CYC < 1 || US_CYC > 255) begin : g_bad_us
         $error("Microsecond count out of range");
      end
      if (`ASR_DO_ACTIVE_MAX_CYC < 4) begin : g_bad_active
         $error("Output enable path slower than allowed");
      end
   endgenerate

   // Parity over the seventeen data bits
   function automatic logic even_parity(input logic [`ASR_WORD_BITS-2:0] bits);
      even_parity = ^bits;
   endfunction

   // ********************
   // Pin synchronisers
   // ********************
   logic cs_n_q;
   logic prog_q;
   logic mode_q;
   logic link_bit_q;
   logic link_done_q;
   logic link_bit;
   logic link_done;

   asr_sync3 #(.INIT(`ASR_SYNC_CS_INIT)) u_sync_cs (
      .clk_in   (clk_in),
      .resetn_in(resetn_in),
      .d_in     (chip_select_n_in),
      .q_out    (cs_n_q)
   );
   asr_sync3 #(.INIT(`ASR_SYNC_LOW_INIT)) u_sync_prog (
      .clk_in   (clk_in),
      .resetn_in(resetn_in),
      .d_in     (prog_in),
      .q_out    (prog_q)
   );
   asr_sync3 #(.INIT(`ASR_SYNC_LOW_INIT)) u_sync_mode (
      .clk_in   (clk_in),
      .resetn_in(resetn_in),
      .d_in     (mode_in),
      .q_out    (mode_q)
   );
   asr_sync3 #(.INIT(`ASR_SYNC_CS_INIT)) u_sync_bit (
      .clk_in   (clk_in),
      .resetn_in(resetn_in),
      .d_in     (link_bit),
      .q_out    (link_bit_q)
   );
   asr_sync3 #(.INIT(`ASR_SYNC_LOW_INIT)) u_sync_done (
      .clk_in   (clk_in),
      .resetn_in(resetn_in),
      .d_in     (link_done),
      .q_out    (link_done_q)
   );

   // ********************
   // Configuration caught once after reset release
   // ********************
   logic       cfg_taken;
   logic [2:0] cfg_wait;
   logic       slow_mode;
   logic       dir_ccw;
   asr_angle_t zero_pos;

   // Taken once the mode synchroniser has refilled after reset
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_taken <= 1'h0;
         cfg_wait  <= 3'h0;
         slow_mode <= 1'h1;
         dir_ccw   <= 1'h0;
         zero_pos  <= '0;
      end else if (!cfg_taken) begin
         cfg_wait <= cfg_wait + 3'h1;
         if (cfg_wait == 3'h5) begin
            cfg_taken <= 1'h1;
            slow_mode <= !mode_q;       // [RQ16] [RQ17]
            dir_ccw   <= fuse_ccw_in;   // [RQ25]
            zero_pos  <= fuse_zero_in;  // [RQ25]
         end
      end
   end

   // ****************************************************************
   // Sample pacing: one period equals the output delay
   // ****************************************************************
   logic [`ASR_DELAY_CNT_W-1:0] pace_cnt;
   wire  [`ASR_DELAY_CNT_W-1:0] pace_last = slow_mode ?
                                   `ASR_DELAY_CNT_W'(SLOW_DELAY_CYC - 1) :
                                   `ASR_DELAY_CNT_W'(FAST_DELAY_CYC - 1);
   wire                         pace_tick = cfg_taken && (pace_cnt == pace_last);

   // Period counter runs at the rate chosen by the mode pin
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pace_cnt          <= '0;
         sample_strobe_out <= 1'h0;
         filter_en_out     <= 1'h0;
      end else begin
         pace_cnt          <= pace_tick ? '0 : pace_cnt + `ASR_DELAY_CNT_W'(1);
         sample_strobe_out <= pace_tick;
         filter_en_out     <= cfg_taken && slow_mode;  // [RQ16] [RQ17]
      end
   end

   // ****************************************************************
   // Angle conversion and sample pipeline
   // ****************************************************************
   asr_angle_t cap_angle;
   logic       cap_ocf;
   logic       cap_cof;
   logic       cap_lin;
   logic       cap_rise;
   logic       cap_fall;
   asr_word_t  pub_word;
   asr_angle_t last_valid;

   // Zero offset and direction; clockwise counts up by default
   wire asr_angle_t rel_angle = dir_ccw ? (zero_pos - raw_angle_in)
                                        : (raw_angle_in - zero_pos);  // [RQ15]
   // Field flags in default coding
   wire rise_code = field_approach_in || field_out_of_range_in;  // [RQ24]
   wire fall_code = field_recede_in || field_out_of_range_in;    // [RQ24]
   // Overflow keeps the last good angle
   wire asr_angle_t pub_angle = cap_cof ? last_valid : cap_angle;  // [RQ12]
   wire [`ASR_WORD_BITS-2:0] pub_bits = {pub_angle, cap_ocf, cap_cof,
                                         cap_lin, cap_rise, cap_fall};  // [RQ6] [RQ7]

   // Capture on each tick, publish the previous capture one period later
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cap_angle  <= '0;
         cap_ocf    <= 1'h0;
         cap_cof    <= 1'h0;
         cap_lin    <= 1'h0;
         cap_rise   <= 1'h0;
         cap_fall   <= 1'h0;
         last_valid <= '0;
         pub_word   <= '0;
      end else if (pace_tick) begin
         cap_angle <= rel_angle;
         cap_ocf   <= offset_comp_done_in;     // [RQ11]
         cap_cof   <= angle_calc_overflow_in;  // [RQ12]
         cap_lin   <= linearity_alarm_in;      // [RQ13]
         cap_rise  <= rise_code;
         cap_fall  <= fall_code;
         pub_word  <= {pub_bits, even_parity(pub_bits)};  // [RQ8] [RQ16] [RQ17]
         if (!cap_cof) begin
            last_valid <= cap_angle;  // [RQ12]
         end
      end
   end

   // ****************************************************************
   // Frame control
   // ****************************************************************
   asr_rd_state_t state;
   asr_rd_state_t next_state;
   logic          cs_n_prev;
   logic          prog_mode;
   asr_word_t     tx_word;

   wire cs_fall = cs_n_prev && !cs_n_q;
   wire cs_rise = !cs_n_prev && cs_n_q;

   // Frame sequence on the synchronised chip select
   always_comb begin
      next_state = state;
      case (state)
         ASR_IDLE: begin
            if (cs_fall) begin
               next_state = ASR_DRIVE;  // [RQ1]
            end
         end
         ASR_DRIVE: begin
            if (cs_rise) begin
               next_state = ASR_IDLE;   // [RQ10]
            end else if (link_done_q) begin
               next_state = ASR_DONE;   // [RQ9]
            end
         end
         ASR_DONE: begin
            if (cs_rise) begin
               next_state = ASR_IDLE;   // [RQ10]
            end
         end
         ASR_PROG: begin
            next_state = ASR_PROG;
         end
         default: begin
            next_state = ASR_IDLE;
         end
      endcase
      if (cs_rise && prog_q) begin
         next_state = ASR_PROG;
      end
   end

   // State, snapshot and programming entry
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state     <= ASR_IDLE;
         cs_n_prev <= 1'h1;
         prog_mode <= 1'h0;
         tx_word   <= '0;
      end else begin
         state     <= next_state;
         cs_n_prev <= cs_n_q;
         if (cs_rise && prog_q) begin
            prog_mode <= 1'h1;  // [RQ25]
         end
         if (cs_fall && state == ASR_IDLE) begin
            tx_word <= pub_word;  // [RQ26]
         end
      end
   end

   // ****************************************************************
   // Link-side shifter
   // ****************************************************************
   // The word crosses as a frozen value: held since chip select fall
   asr_link_shift #(.WORD_BITS(`ASR_WORD_BITS)) u_link (
      .link_clk_in(read_clk_in),
      .clear_in   (chip_select_n_in),
      .word_in    (tx_word),
      .bit_out    (link_bit),
      .done_out   (link_done)
   );

   // Serial output drivers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sdo_out       <= 1'h1;
         sdo_oe_out    <= 1'h0;
         prog_mode_out <= 1'h0;
      end else begin
         sdo_out       <= (next_state == ASR_DRIVE) ? link_bit_q : 1'h1;  // [RQ1] [RQ4]
         sdo_oe_out    <= (next_state == ASR_DRIVE);                      // [RQ9]
         prog_mode_out <= prog_mode;
      end
   end

   // ****************************************************************
   // PWM output and field pins
   // ****************************************************************
   logic [7:0]                us_div;
   logic [`ASR_PWM_CNT_W-1:0] us_cnt;
   asr_angle_t                pwm_code;

   wire us_tick  = (us_div == 8'(US_CYC - 1));
   wire pwm_wrap = us_tick && (us_cnt == `ASR_PWM_CNT_W'(`ASR_PWM_PERIOD_US - 1));

   // Microsecond grid; high time is code plus one microseconds
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         us_div   <= 8'h00;
         us_cnt   <= '0;
         pwm_code <= '0;
         pwm_out  <= 1'h0;
      end else begin
         us_div <= us_tick ? 8'h00 : us_div + 8'h01;
         if (pwm_wrap) begin
            us_cnt   <= '0;
            pwm_code <= pub_word[`ASR_WORD_BITS-1:`ASR_POS_ANGLE_LSB];  // [RQ19]
         end else if (us_tick) begin
            us_cnt <= us_cnt + `ASR_PWM_CNT_W'(1);
         end
         pwm_out <= (us_cnt <= {1'h0, pwm_code});  // [RQ19]
      end
   end

   // Open-drain field pins pull low while their flag is set
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         field_rising_n_out     <= 1'h0;
         field_rising_n_oe_out  <= 1'h0;
         field_falling_n_out    <= 1'h0;
         field_falling_n_oe_out <= 1'h0;
      end else begin
         field_rising_n_out     <= 1'h0;
         field_rising_n_oe_out  <= pub_word[`ASR_POS_FIELD_RISING];   // [RQ24]
         field_falling_n_out    <= 1'h0;
         field_falling_n_oe_out <= pub_word[`ASR_POS_FIELD_FALLING];  // [RQ24]
      end
   end
endmodule

`default_nettype wire

// ### asr_readout_checker.sv
// Purpose: Port checks of the read-out.
// Assumes: One clk_in domain, resetn_in active low.
// Notes:   Bound from the testbench top file.
`timescale 1ns/100ps
`default_nettype none

module asr_readout_checker #(
   parameter int US_CYC = 40
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic resetn_in,
   // Watched ports
   input  wire logic chip_select_n_in,
   input  wire logic mode_in,
   input  wire logic sdo_out,
   input  wire logic sdo_oe_out,
   input  wire logic sample_strobe_out,
   input  wire logic filter_en_out,
   input  wire logic field_rising_n_out,
   input  wire logic field_rising_n_oe_out,
   input  wire logic pwm_out,
   input  wire logic prog_mode_out
);
   // ********************
   // PWM cycle counter
   // ********************
   logic [17:0] pwm_cnt;
   logic        pwm_seen;

   // Cycles since the last PWM rise
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pwm_cnt  <= 18'h0;
         pwm_seen <= 1'h0;
      end else begin
         pwm_cnt  <= $rose(pwm_out) ? 18'h1 : pwm_cnt + 18'h1;
         pwm_seen <= pwm_seen | $rose(pwm_out);
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence drive_s; sdo_oe_out && sdo_out; endsequence
   sequence idle_s; !sdo_oe_out; endsequence

   oe_start_a: assert property ($fell(chip_select_n_in) && !prog_mode_out |-> ##[1:6] drive_s)
      else $error("no drive");
   cs_release_a: assert property ($rose(chip_select_n_in) |-> ##[1:6] idle_s)
      else $error("no release");
   cs_idle_a: assert property (chip_select_n_in [*7] |-> idle_s)
      else $error("drive when idle");
   prog_quiet_a: assert property (prog_mode_out [*8] |-> idle_s)
      else $error("drive in prog");
   prog_hold_a: assert property (prog_mode_out |=> prog_mode_out)
      else $error("prog left");
   strobe_gap_a: assert property ($rose(sample_strobe_out) |=> !sample_strobe_out [*8])
      else $error("strobe gap");
   filter_mode_a: assert property (filter_en_out |-> !mode_in)
      else $error("filter mode");
   field_pin_a: assert property (field_rising_n_oe_out |-> !field_rising_n_out)
      else $error("field pin");
   pwm_period_a: assert property ($rose(pwm_out) && pwm_seen |-> pwm_cnt == 4097 * US_CYC)
      else $error("pwm period wrong");
   pwm_high_a: assert property ($fell(pwm_out) |-> pwm_cnt <= 4096 * US_CYC)
      else $error("pwm high");
endmodule
`default_nettype wire

// ### asr_sync3.sv
// Purpose: Three-flop synchroniser with agreement filter.
// Assumes: d_in is asynchronous to clk_in.
// Notes:   Stage one feeds stage two only.
`timescale 1ns/100ps
`default_nettype none

module asr_sync3 #(
   parameter logic INIT = 1'h0
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic resetn_in,
   // Data
   input  wire logic d_in,
   output logic      q_out
);
   logic s1;
   logic s2;
   logic s3;

   // ********************
   // Synchroniser chain and agreement filter
   // ********************
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1    <= INIT;
         s2    <= INIT;
         s3    <= INIT;
         q_out <= INIT;
      end else begin
         s1 <= d_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q_out <= s3;
         end
      end
   end
endmodule

`default_nettype wire

// ### test_asr_readout.sv
// Purpose: Bench for the angle read-out.
// Assumes: Short pacing and microsecond counts.
// Notes:   Inputs change at the falling clock edge.
`timescale 1ns/100ps
`default_nettype none

module test_asr_readout
   import asr_pkg::*;
;
   localparam int SLOW = 40;
   localparam int FAST = 20;
   localparam int USC  = 2;
   localparam logic [4:0] ST [4] = '{5'h14, 5'h12, 5'h11, 5'h13};
   logic clk = 1'b0, resetn = 1'b0, lclk = 1'b0, rclk, cs_n, prog, sdo, sdo_oe;
   logic mode = 1'b0, ccw = 1'b0, offset_comp_done = 1'b0, angle_calc_overflow = 1'b0, lin = 1'b0;
   logic app = 1'b0, rec = 1'b0, oor = 1'b0, strobe, filt, fr_n, fr_oe, ff_n, ff_oe, pwm, pmode;
   asr_angle_t zero = 12'h000, raw = 12'h000;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;

   always #12.5 clk = ~clk;
   always #3 lclk = ~lclk;

   asr_readout #(.SLOW_DELAY_CYC(SLOW), .FAST_DELAY_CYC(FAST), .US_CYC(USC)) asr_readout_inst (
      .clk_in(clk), .resetn_in(resetn), .read_clk_in(rclk), .chip_select_n_in(cs_n),
      .prog_in(prog), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .mode_in(mode), .fuse_ccw_in(ccw),
      .fuse_zero_in(zero), .raw_angle_in(raw), .offset_comp_done_in(offset_comp_done),
      .angle_calc_overflow_in(angle_calc_overflow), .linearity_alarm_in(lin), .field_approach_in(app),
      .field_recede_in(rec), .field_out_of_range_in(oor), .sample_strobe_out(strobe),
      .filter_en_out(filt), .field_rising_n_out(fr_n), .field_rising_n_oe_out(fr_oe),
      .field_falling_n_out(ff_n), .field_falling_n_oe_out(ff_oe), .pwm_out(pwm),
      .prog_mode_out(pmode));

   asr_host_model asr_host_model_inst (
      .link_clk_in(lclk), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .read_clk_out(rclk),
      .chip_select_n_out(cs_n), .prog_out(prog));

   // ********************
   // Tasks
   // ********************
   task chk(input logic [17:0] seen, input logic [17:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic asr_word_t mkw(asr_angle_t a, logic [4:0] f);
      logic [16:0] b;
      b = {a, f};
      return {b, ^b};
   endfunction

   // Reset with mode and fuses held stable through it
   task do_reset(input logic m, input logic c, input asr_angle_t z);
      @(negedge clk);
      resetn = 1'b0;
      mode = m;
      ccw = c;
      zero = z;
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      repeat (8) @(negedge clk);
   endtask

   // Front-end value and flags {ocf, cof, lin, app, rec, oor}, then settle
   task set_fe(input asr_angle_t r, input logic [5:0] f);
      @(negedge clk);
      raw = r;
      {offset_comp_done, angle_calc_overflow, lin, app, rec, oor} = f;
      repeat (4 * SLOW) @(negedge clk);
   endtask

   task frame(input asr_word_t exp, input logic live);
      asr_word_t w;
      logic act, rel;
      asr_host_model_inst.read_frame(w, act, rel);
      chk(18'(act), 18'(live));
      if (live) begin
         chk(w, exp);
         chk(18'(rel), 18'h1);
      end
   endtask

   // Cycles between two sample strobes
   task gap(input int exp);
      int n;
      n = 0;
      while (strobe !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      n = 1;
      while (strobe !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk(18'(n), 18'(exp));
   endtask

   task pwm_high(input int exp);
      int n;
      n = 0;
      repeat (2 * 4097 * USC) @(negedge clk);
      while (pwm !== 1'b1 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (pwm === 1'b1 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      chk(18'(n), 18'(exp));
   endtask

   task test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         test_done();
      end
   end

   // ********************
   // Tests
   // ********************
   initial begin
      do_reset(1'b0, 1'b0, 12'h123);
      chk(18'(filt), 18'h1);
      gap(SLOW);
      set_fe(12'hABC, 6'h20);
      frame(mkw(12'h999, 5'h10), 1'b1);
      $display("test basic done");
      for (int i = 0; i < 4; i++) begin
         set_fe(12'h123 + 12'(i * 'h111), {2'b10, 4'h8 >> i});
         frame(mkw(12'(i * 'h111), ST[i]), 1'b1);
         chk(18'({fr_oe, ff_oe}), 18'(ST[i][1:0]));
      end
      $display("test status done");
      @(negedge clk);
      zero = 12'h000;
      set_fe(12'h555, 6'h30);
      frame(mkw(12'h333, 5'h18), 1'b1);
      set_fe(12'h12A, 6'h20);
      frame(mkw(12'h007, 5'h10), 1'b1);
      pwm_high(8 * USC);
      $display("test overflow and pwm done");
      do_reset(1'b1, 1'b1, 12'h100);
      chk(18'(filt), 18'h0);
      gap(FAST);
      set_fe(12'h0FF, 6'h20);
      frame(mkw(12'h001, 5'h10), 1'b1);
      $display("test fast ccw done");
      asr_host_model_inst.enter_prog({1'b1, 12'h2A5, 3'h5});
      chk(18'(pmode), 18'h1);
      frame(18'h0, 1'b0);
      $display("test prog done");
      test_done();
   end
endmodule

bind asr_readout asr_readout_checker #(.US_CYC(US_CYC)) asr_readout_checker_inst (
   .clk_in(clk_in), .resetn_in(resetn_in), .chip_select_n_in(chip_select_n_in),
   .mode_in(mode_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
   .sample_strobe_out(sample_strobe_out), .filter_en_out(filter_en_out),
   .field_rising_n_out(field_rising_n_out), .field_rising_n_oe_out(field_rising_n_oe_out),
   .pwm_out(pwm_out), .prog_mode_out(prog_mode_out));
`default_nettype wire
